// ### hdl/duf_dac_ctrl.sv
// Converter control: enable, update scheduling, data bytes and word latch.
// Operation
// - Control bit 7 enables converter; 0 disables pin and shuts down.
// - Control bits 6-5 unused: read as 00, writes ignored.
// - Update mode 00: output latch loads on each high data byte write.
// - Modes 01, 10, 11: latch loads on timer 3, 4, 2 overflow.
// - Format 000: word is high[3:0] then whole low byte.
// - Format 001: word is high[4:0] then low[7:1].
// - Format 010: word is high[5:0] then low[7:2].
// - Format 011: word is high[6:0] then low[7:3].
// - Format 1xx: word is whole high byte then low[7:4].
// - In mode 00 a low byte write is held until the high write.
// - In timer modes both bytes are held until the selected overflow.
`timescale 1ns/1ns
`default_nettype none

module duf_dac_ctrl (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Special function register bus
  input wire logic [duf_pkg::ADDR_W-1:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [duf_pkg::DATA_W-1:0] sfr_wdata_i,
  output logic [duf_pkg::DATA_W-1:0] sfr_rdata_o,
  // Timer overflow pulses
  input wire logic tmr2_ovf_i,
  input wire logic tmr3_ovf_i,
  input wire logic tmr4_ovf_i,
  // Converter core
  output logic [duf_pkg::WORD_W-1:0] dac_code_o,
  output logic dac_pin_drive_o,
  output logic dac_shutdown_o
);
  import duf_pkg::*;

  // ==========================================================================
  // State.
  typedef struct packed {
    logic en;
    logic [MODE_W-1:0] mode;
    logic [FMT_W-1:0] fmt;
    logic [DATA_W-1:0] high;
    logic [DATA_W-1:0] low;
    logic [WORD_W-1:0] code;
    logic [DATA_W-1:0] rdata;
  } duf_state_t;

  localparam duf_state_t ST_RESET = '{
    en: CTRL_RESET[EN_BIT],
    mode: CTRL_RESET[MODE_LSB +: MODE_W],
    fmt: CTRL_RESET[FMT_LSB +: FMT_W],
    high: DATA_RESET,
    low: DATA_RESET,
    code: CODE_RESET,
    rdata: UNMAPPED_READ
  };

  duf_state_t st_reg;
  duf_state_t st_next;
  logic wr_ctrl;
  logic wr_high;
  logic wr_low;
  logic sel_ovf;
  logic update;

  duf_fmt_if fmt_bus ();

  duf_word_format u_word_format (
    .bus(fmt_bus.fmt_unit)
  );

  // ==========================================================================
  // Register decode and next state.
  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == CTRL_ADDR);
  assign wr_high = sfr_wr_i && (sfr_addr_i == HIGH_ADDR);
  assign wr_low = sfr_wr_i && (sfr_addr_i == LOW_ADDR);

  // The formatter sees the bytes as they will stand after this cycle's write, so a
  // high byte write and the latch load it triggers complete on the same edge. The
  // inputs are built from the strobes, not from the next state, so no loop closes.
  assign fmt_bus.high = wr_high ? sfr_wdata_i : st_reg.high;
  assign fmt_bus.low = wr_low ? sfr_wdata_i : st_reg.low;
  assign fmt_bus.fmt = wr_ctrl ? sfr_wdata_i[FMT_LSB +: FMT_W] : st_reg.fmt;

  always_comb begin
    case (st_reg.mode)
      MODE_TIMER3: begin
        sel_ovf = tmr3_ovf_i;
      end
      MODE_TIMER4: begin
        sel_ovf = tmr4_ovf_i;
      end
      MODE_TIMER2: begin
        sel_ovf = tmr2_ovf_i;
      end
      default: begin
        sel_ovf = 1'b0;
      end
    endcase
  end

  // The mode in force before a control write decides this cycle's update.
  assign update = (st_reg.mode == MODE_ON_WRITE) ? wr_high : sel_ovf;

  always_comb begin
    st_next = st_reg;
    if (wr_ctrl) begin
      st_next.en = sfr_wdata_i[EN_BIT];
      st_next.mode = sfr_wdata_i[MODE_LSB +: MODE_W];
      st_next.fmt = sfr_wdata_i[FMT_LSB +: FMT_W];
    end
    if (wr_high) begin
      st_next.high = sfr_wdata_i;
    end
    if (wr_low) begin
      st_next.low = sfr_wdata_i;
    end
    // Bytes sit in the holding registers until an update copies them over.
    if (update) begin
      st_next.code = fmt_bus.word;
    end
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        CTRL_ADDR: begin
          st_next.rdata = {st_reg.en, UNUSED_READ, st_reg.mode, st_reg.fmt};
        end
        HIGH_ADDR: begin
          st_next.rdata = st_reg.high;
        end
        LOW_ADDR: begin
          st_next.rdata = st_reg.low;
        end
        default: begin
          st_next.rdata = UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs.
  assign sfr_rdata_o = st_reg.rdata;
  assign dac_code_o = st_reg.code;
  assign dac_pin_drive_o = st_reg.en;
  assign dac_shutdown_o = ~st_reg.en;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_high_write;
    (st_reg.mode == MODE_ON_WRITE) && wr_high;
  endsequence

  sequence s_timer_idle;
    (st_reg.mode != MODE_ON_WRITE) && !sel_ovf;
  endsequence

  property p_enable;
    wr_ctrl |=> (dac_pin_drive_o == $past(sfr_wdata_i[EN_BIT])) &&
      (dac_shutdown_o != dac_pin_drive_o);
  endproperty
  a_enable: assert property (p_enable) else $error("enable bit not reflected on pin");

  property p_unused_bits;
    (sfr_rd_i && (sfr_addr_i == CTRL_ADDR)) |=>
      (sfr_rdata_o[UNUSED_MSB:UNUSED_LSB] == UNUSED_READ);
  endproperty
  a_unused_bits: assert property (p_unused_bits) else $error("unused bits read nonzero");

  property p_on_demand;
    s_high_write |=> (dac_code_o == $past(fmt_bus.word));
  endproperty
  a_on_demand: assert property (p_on_demand) else $error("high write did not load latch");

  property p_timer_load;
    ((st_reg.mode != MODE_ON_WRITE) && sel_ovf) |=> (dac_code_o == $past(fmt_bus.word));
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("overflow did not load latch");

  property p_fmt4;
    (s_high_write and (st_next.fmt == FMT_HI4)) |=>
      (dac_code_o == {st_reg.high[3:0], st_reg.low});
  endproperty
  a_fmt4: assert property (p_fmt4) else $error("format 000 word wrong");

  property p_fmt5;
    (s_high_write and (st_next.fmt == FMT_HI5)) |=>
      (dac_code_o == {st_reg.high[4:0], st_reg.low[7:1]});
  endproperty
  a_fmt5: assert property (p_fmt5) else $error("format 001 word wrong");

  property p_fmt6;
    (s_high_write and (st_next.fmt == FMT_HI6)) |=>
      (dac_code_o == {st_reg.high[5:0], st_reg.low[7:2]});
  endproperty
  a_fmt6: assert property (p_fmt6) else $error("format 010 word wrong");

  property p_fmt7;
    (s_high_write and (st_next.fmt == FMT_HI7)) |=>
      (dac_code_o == {st_reg.high[6:0], st_reg.low[7:3]});
  endproperty
  a_fmt7: assert property (p_fmt7) else $error("format 011 word wrong");

  property p_fmt8;
    (s_high_write and st_next.fmt[2]) |=> (dac_code_o == {st_reg.high, st_reg.low[7:4]});
  endproperty
  a_fmt8: assert property (p_fmt8) else $error("format 1xx word wrong");

  property p_low_held;
    ((st_reg.mode == MODE_ON_WRITE) && wr_low && !wr_high) |=> $stable(dac_code_o);
  endproperty
  a_low_held: assert property (p_low_held) else $error("low write changed output");

  property p_timer_held;
    s_timer_idle |=> $stable(dac_code_o);
  endproperty
  a_timer_held: assert property (p_timer_held) else $error("output moved without overflow");

endmodule

`default_nettype wire

// ### hdl/duf_pkg.sv
// Constants shared by the converter update and format control block.
package duf_pkg;

  // ==========================================================================
  // Register bus and map.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int WORD_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'hD4;
  localparam logic [ADDR_W-1:0] HIGH_ADDR = 8'hD3;
  localparam logic [ADDR_W-1:0] LOW_ADDR = 8'hD2;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  // ==========================================================================
  // Control register fields.
  localparam int EN_BIT = 7;
  localparam int UNUSED_MSB = 6;
  localparam int UNUSED_LSB = 5;
  localparam int MODE_LSB = 3;
  localparam int MODE_W = 2;
  localparam int FMT_LSB = 0;
  localparam int FMT_W = 3;
  localparam logic [1:0] UNUSED_READ = 2'h0;

  // ==========================================================================
  // Update mode encodings.
  localparam logic [MODE_W-1:0] MODE_ON_WRITE = 2'h0;
  localparam logic [MODE_W-1:0] MODE_TIMER3 = 2'h1;
  localparam logic [MODE_W-1:0] MODE_TIMER4 = 2'h2;
  localparam logic [MODE_W-1:0] MODE_TIMER2 = 2'h3;

  // ==========================================================================
  // Word format encodings; any code with the top bit set selects the byte-wide layout.
  localparam logic [FMT_W-1:0] FMT_HI4 = 3'h0;
  localparam logic [FMT_W-1:0] FMT_HI5 = 3'h1;
  localparam logic [FMT_W-1:0] FMT_HI6 = 3'h2;
  localparam logic [FMT_W-1:0] FMT_HI7 = 3'h3;
  localparam logic [FMT_W-1:0] FMT_HI8 = 3'h4;

  // ==========================================================================
  // Reset values.
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [WORD_W-1:0] CODE_RESET = 12'h000;

endpackage

// ### hdl/duf_fmt_if.sv
// Interface carrying the data bytes and format code to the word formatter.
`timescale 1ns/1ns
`default_nettype none

interface duf_fmt_if;
  logic [7:0] high;
  logic [7:0] low;
  logic [2:0] fmt;
  logic [11:0] word;

  modport fmt_src (
    output high,
    output low,
    output fmt,
    input word
  );

  modport fmt_unit (
    input high,
    input low,
    input fmt,
    output word
  );
endinterface

`default_nettype wire

// ### hdl/duf_word_format.sv
// Word formatter: assembles the 12-bit converter word from the two data bytes.
`timescale 1ns/1ns
`default_nettype none

module duf_word_format (
  // Bytes in, word out
  duf_fmt_if.fmt_unit bus
);
  import duf_pkg::*;

  always_comb begin
    case (bus.fmt)
      FMT_HI4: begin
        bus.word = {bus.high[3:0], bus.low};
      end
      FMT_HI5: begin
        bus.word = {bus.high[4:0], bus.low[7:1]};
      end
      FMT_HI6: begin
        bus.word = {bus.high[5:0], bus.low[7:2]};
      end
      FMT_HI7: begin
        bus.word = {bus.high[6:0], bus.low[7:3]};
      end
      default: begin
        bus.word = {bus.high, bus.low[7:4]};
      end
    endcase
  end

endmodule

`default_nettype wire

// ### dv/dac_update_and_format_control_tb.sv
// Self-checking bench for the converter update and format control block.
`timescale 1ns/1ns
`default_nettype none

module dac_update_and_format_control_tb;
  import duf_pkg::*;

  // ==========================================================================
  // Design signals and reference model state.
  logic sys_clk_i, rstn_i, sfr_wr_i, sfr_rd_i;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic tmr2_ovf_i, tmr3_ovf_i, tmr4_ovf_i, dac_pin_drive_o, dac_shutdown_o;
  logic [11:0] dac_code_o, m_code;
  logic [7:0] m_ctrl, m_hi, m_lo;
  integer err_count, checked, seed, f, md, k;

  duf_dac_ctrl uut (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o),
    .tmr2_ovf_i(tmr2_ovf_i),
    .tmr3_ovf_i(tmr3_ovf_i),
    .tmr4_ovf_i(tmr4_ovf_i),
    .dac_code_o(dac_code_o),
    .dac_pin_drive_o(dac_pin_drive_o),
    .dac_shutdown_o(dac_shutdown_o)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================================
  // Model, compare and bus tasks.
  function automatic logic [11:0] fmt_word(input logic [7:0] h, input logic [7:0] l,
                                           input logic [2:0] s);
    case (s)
      3'h0: return {h[3:0], l};
      3'h1: return {h[4:0], l[7:1]};
      3'h2: return {h[5:0], l[7:2]};
      3'h3: return {h[6:0], l[7:3]};
      default: return {h, l[7:4]};
    endcase
  endfunction

  task automatic flag(input string what);
    err_count++;
    $display("mismatch at %0t: %s", $time, what);
  endtask

  task automatic cmp_code();
    checked++;
    if (dac_code_o !== m_code) flag("converter word");
  endtask

  task automatic cmp_pin();
    checked++;
    if ({dac_pin_drive_o, dac_shutdown_o} !== {m_ctrl[7], ~m_ctrl[7]}) flag("enable outputs");
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge sys_clk_i);
    sfr_rd_i = 1'b0;
    checked++;
    if (sfr_rdata_o !== ((a == CTRL_ADDR) ? m_ctrl :
                         (a == HIGH_ADDR) ? m_hi :
                         (a == LOW_ADDR) ? m_lo : UNMAPPED_READ)) flag("read data");
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge sys_clk_i);
    sfr_wr_i = 1'b0;
    if (a == CTRL_ADDR) m_ctrl = d & 8'h9F;
    if (a == HIGH_ADDR) m_hi = d;
    if (a == LOW_ADDR) m_lo = d;
    if (a == HIGH_ADDR && m_ctrl[4:3] == MODE_ON_WRITE) begin
      m_code = fmt_word(m_hi, m_lo, m_ctrl[2:0]);
    end
  endtask

  // Index 0, 1, 2 pulses the overflow of timer 2, 3, 4 for one cycle.
  task automatic ovf(input integer t);
    @(negedge sys_clk_i);
    {tmr4_ovf_i, tmr3_ovf_i, tmr2_ovf_i} = 3'(1 << t);
    @(negedge sys_clk_i);
    {tmr4_ovf_i, tmr3_ovf_i, tmr2_ovf_i} = 3'h0;
    if (m_ctrl[4:3] != MODE_ON_WRITE && (m_ctrl[4:3] % 3) == t) begin
      m_code = fmt_word(m_hi, m_lo, m_ctrl[2:0]);
    end
  endtask

  task automatic stop_test();
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    seed = 32'h856d;
    err_count = 0;
    checked = 0;
    {sfr_addr_i, sfr_wdata_i} = 16'h0000;
    {sfr_wr_i, sfr_rd_i, tmr2_ovf_i, tmr3_ovf_i, tmr4_ovf_i} = 5'h00;
    {m_ctrl, m_hi, m_lo} = {CTRL_RESET, DATA_RESET, DATA_RESET};
    m_code = CODE_RESET;
    rstn_i = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    cmp_code();
    cmp_pin();
    wr(CTRL_ADDR, 8'hE0);
    cmp_pin();
    rd(CTRL_ADDR);
    rd(8'h55);
    for (f = 0; f < 8; f++) begin
      wr(CTRL_ADDR, {1'b1, 2'h3, MODE_ON_WRITE, 3'(f)});
      wr(LOW_ADDR, 8'($random(seed)));
      cmp_code();
      wr(HIGH_ADDR, 8'($random(seed)));
      cmp_code();
    end
    for (md = 0; md < 4; md++) begin
      wr(CTRL_ADDR, {md[0], 2'h2, 2'(md), 3'(md + 1)});
      cmp_pin();
      rd(CTRL_ADDR);
      wr(LOW_ADDR, 8'($random(seed)));
      cmp_code();
      wr(HIGH_ADDR, 8'($random(seed)));
      cmp_code();
      rd(HIGH_ADDR);
      rd(LOW_ADDR);
      for (k = 0; k < 3; k++) begin
        ovf(k);
        cmp_code();
      end
    end
    // A reset in mid-run must drop the latch and the enable back to their idle values.
    rstn_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    {m_ctrl, m_hi, m_lo} = {CTRL_RESET, DATA_RESET, DATA_RESET};
    m_code = CODE_RESET;
    cmp_code();
    cmp_pin();
    rd(CTRL_ADDR);
    rd(HIGH_ADDR);
    stop_test();
  end

  initial begin
    #20000;
    err_count++;
    stop_test();
  end
endmodule

`default_nettype wire
